/* design/ladder_dac_control.v */
// apb register file and analog switch control of the ladder converter
`timescale 1ns/100ps
`include "ladder_dac_regs.vh"
module ladder_dac_control #(
    parameter LEVEL_BITS = 5
) (
    input  wire                       pclk,
    input  wire                       presetn,
    input  wire                       psel,
    input  wire                       penable,
    input  wire                       pwrite,
    input  wire [11:0]                paddr,
    input  wire [31:0]                pwdata,
    output reg  [31:0]                prdata,
    output reg                        pready,
    output reg                        pslverr,
    input  wire                       pin_digital_in,
    input  wire                       pin_port_out,
    input  wire                       pin_port_oe_n,
    output reg                        pin_digital_read,
    output reg                        pin_out,
    output reg                        pin_oe_n,
    output reg                        ladder_run,
    output reg  [(1<<LEVEL_BITS)-1:0] ladder_tap,
    output reg  [2:0]                 top_src,
    output reg  [1:0]                 bottom_src,
    output reg                        top_connect,
    output reg                        bottom_connect,
    output reg                        clamp_top,
    output reg                        clamp_bottom,
    output reg                        ref_to_pin
);
    reg  [7:0]                  ctrl_zero_q;
    reg  [7:0]                  level_select_q;
    wire                        setup_phase;
    wire                        access;
    wire                        hit_ctrl;
    wire                        hit_level;
    wire                        hit_status;
    wire                        mapped;
    wire [(1<<LEVEL_BITS)-1:0]  tap_d;
    wire [2:0]                  top_d;
    wire [1:0]                  bottom_d;
    wire                        top_conn_d;
    wire                        bot_conn_d;
    wire                        clamp_top_d;
    wire                        clamp_bot_d;
    wire                        converter_on;
    wire                        low_power_source_pick;
    wire                        ref_pin_drive;
    wire [1:0]                  pos_source_sel;
    wire                        neg_source_sel;
    wire [4:0]                  level_code;
    reg  [31:0]                 rdata_d;

    assign converter_on          = ctrl_zero_q[`BIT_CONVERTER_ON];
    assign low_power_source_pick = ctrl_zero_q[`BIT_LOW_POWER_PICK];
    assign ref_pin_drive         = ctrl_zero_q[`BIT_REF_PIN_DRIVE];
    assign pos_source_sel = ctrl_zero_q[`POS_SEL_HI:`POS_SEL_LO];
    assign neg_source_sel = ctrl_zero_q[`BIT_NEG_SOURCE_SEL];
    assign level_code     = level_select_q[`LEVEL_HI:0];

    // slave answers one cycle after the setup cycle
    assign setup_phase = psel & ~penable;
    assign access      = psel & penable & pready;
    assign hit_ctrl    = (paddr == `CTRL_ZERO_OFFSET);
    assign hit_level   = (paddr == `LEVEL_SEL_OFFSET);
    assign hit_status  = (paddr == `STATUS_OFFSET);
    assign mapped      = hit_ctrl | hit_level | hit_status;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata  <= (setup_phase & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // reset is the only thing that clears the controls; no sleep input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_zero_q    <= `CTRL_ZERO_RESET;
            level_select_q <= `LEVEL_SEL_RESET;
        end else if (access & pwrite) begin
            if (hit_ctrl) begin
                ctrl_zero_q <= pwdata[7:0] & `CTRL_ZERO_WMASK;
            end
            if (hit_level) begin
                level_select_q <= pwdata[7:0] & `LEVEL_SEL_WMASK;
            end
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d[7:0] = ctrl_zero_q;
        end else if (hit_level) begin
            rdata_d[7:0] = level_select_q;
        end else if (hit_status) begin
            rdata_d[7:0] = {2'h0, top_connect, bottom_connect,
                            clamp_top, clamp_bottom, ref_to_pin,
                            ladder_run};
        end
    end

    ladder_tap_decode #(
        .LEVEL_BITS (LEVEL_BITS)
    ) u_tap (
        .level_code (level_code[LEVEL_BITS-1:0]),
        .run        (converter_on),
        .tap_sel    (tap_d)
    );

    ladder_source_switch u_src (
        .converter_on          (converter_on),
        .low_power_source_pick (low_power_source_pick),
        .pos_source_sel        (pos_source_sel),
        .neg_source_sel        (neg_source_sel),
        .level_code            (level_code),
        .top_src_onehot        (top_d),
        .bottom_src_onehot     (bottom_d),
        .top_connect           (top_conn_d),
        .bottom_connect        (bot_conn_d),
        .clamp_top             (clamp_top_d),
        .clamp_bottom          (clamp_bot_d)
    );

    // analog controls registered; output = bottom + span*tap/32
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_run     <= 1'b0;
            ladder_tap     <= {(1<<LEVEL_BITS){1'b0}};
            top_src        <= 3'h0;
            bottom_src     <= 2'h0;
            top_connect    <= 1'b0;
            bottom_connect <= 1'b0;
            clamp_top      <= 1'b0;
            clamp_bottom   <= 1'b0;
            ref_to_pin     <= 1'b0;
        end else begin
            ladder_run     <= converter_on;
            ladder_tap     <= tap_d;
            top_src        <= top_d;
            bottom_src     <= bottom_d;
            top_connect    <= top_conn_d;
            bottom_connect <= bot_conn_d;
            clamp_top      <= clamp_top_d;
            clamp_bottom   <= clamp_bot_d;
            ref_to_pin     <= ref_pin_drive;
        end
    end

    // pin override while the reference is routed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out          <= 1'b0;
            pin_oe_n         <= 1'b1;
            pin_digital_read <= 1'b0;
        end else if (ref_pin_drive) begin
            pin_out          <= 1'b0;
            pin_oe_n         <= 1'b1;
            pin_digital_read <= 1'b0;
        end else begin
            pin_out          <= pin_port_out;
            pin_oe_n         <= pin_port_oe_n;
            pin_digital_read <= pin_digital_in;
        end
    end
endmodule

/* design/ladder_dac_regs.vh */
// register offsets, field positions and reset values of the ladder converter
`ifndef LADDER_DAC_REGS_VH
`define LADDER_DAC_REGS_VH

`define CTRL_ZERO_OFFSET   12'h000
`define LEVEL_SEL_OFFSET   12'h004
`define STATUS_OFFSET      12'h008

`define CTRL_ZERO_RESET    8'h00
`define LEVEL_SEL_RESET    8'h00
`define CTRL_ZERO_WMASK    8'hed
`define LEVEL_SEL_WMASK    8'h1f

`define BIT_CONVERTER_ON   7
`define BIT_LOW_POWER_PICK 6
`define BIT_REF_PIN_DRIVE  5
`define POS_SEL_HI         3
`define POS_SEL_LO         2
`define BIT_NEG_SOURCE_SEL 0
`define LEVEL_HI           4

`define POS_SRC_SUPPLY     2'h0
`define POS_SRC_EXT_REF    2'h1
`define POS_SRC_FIXED_REF  2'h2

`endif

/* design/ladder_source_switch.v */
// source connect, disconnect and clamp decision for the ladder ends
`timescale 1ns/100ps
`include "ladder_dac_regs.vh"
module ladder_source_switch (
    input  wire       converter_on,
    input  wire       low_power_source_pick,
    input  wire [1:0] pos_source_sel,
    input  wire       neg_source_sel,
    input  wire [4:0] level_code,
    output wire [2:0] top_src_onehot,
    output wire [1:0] bottom_src_onehot,
    output wire       top_connect,
    output wire       bottom_connect,
    output wire       clamp_top,
    output wire       clamp_bottom
);
    // while the converter is off one end of the ladder is dropped; low power pick set drops the bottom, clear drops the top
    assign bottom_connect = converter_on | ~low_power_source_pick;
    assign top_connect    = converter_on | low_power_source_pick;
    assign clamp_top    = ~converter_on & low_power_source_pick
                        & (&level_code);
    assign clamp_bottom = ~converter_on & ~low_power_source_pick
                        & ~(|level_code);
    // reserved positive select code picks no source
    assign top_src_onehot = {pos_source_sel == `POS_SRC_FIXED_REF,
                             pos_source_sel == `POS_SRC_EXT_REF,
                             pos_source_sel == `POS_SRC_SUPPLY};
    assign bottom_src_onehot = {neg_source_sel, ~neg_source_sel};
endmodule

/* design/ladder_tap_decode.v */
// one-hot ladder tap select from the level code while run is high, no tap selected while run is low
`timescale 1ns/100ps
module ladder_tap_decode #(
    parameter LEVEL_BITS = 5
) (
    input  wire [LEVEL_BITS-1:0]      level_code,
    input  wire                       run,
    output reg  [(1<<LEVEL_BITS)-1:0] tap_sel
);
    integer i;
    always @* begin
        tap_sel = {(1<<LEVEL_BITS){1'b0}};
        for (i = 0; i < (1 << LEVEL_BITS); i = i + 1) begin
            if (run && (level_code == i[LEVEL_BITS-1:0])) begin
                tap_sel[i] = 1'b1;
            end
        end
    end
endmodule

/* test/ladder_dac_control_asserts.sv */
// port-level assertions for the ladder converter control block
`timescale 1ns/100ps
module ladder_dac_control_asserts #(
    parameter LEVEL_BITS = 5
) (
    input logic                       pclk,
    input logic                       presetn,
    input logic                       pin_digital_read,
    input logic                       pin_out,
    input logic                       pin_oe_n,
    input logic                       ladder_run,
    input logic [(1<<LEVEL_BITS)-1:0] ladder_tap,
    input logic [1:0]                 bottom_src,
    input logic                       top_connect,
    input logic                       bottom_connect,
    input logic                       clamp_top,
    input logic                       clamp_bottom,
    input logic                       ref_to_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tap_off;
        !ladder_run |-> ladder_tap == '0;
    endproperty
    a_tap_off: assert property (p_tap_off)
        else $error("ladder tap set while converter off");
    property p_tap_one;
        ladder_run |-> $onehot(ladder_tap);
    endproperty
    a_tap_one: assert property (p_tap_one)
        else $error("ladder tap not one-hot while running");
    property p_bottom_src;
        !$rose(presetn) |-> $onehot(bottom_src);
    endproperty
    a_bottom_src: assert property (p_bottom_src)
        else $error("bottom source select not one-hot");
    property p_clamp_top;
        clamp_top |-> !ladder_run && top_connect && !bottom_connect;
    endproperty
    a_clamp_top: assert property (p_clamp_top)
        else $error("top clamp with wrong source connection");
    property p_clamp_bot;
        clamp_bottom |-> !ladder_run && bottom_connect && !top_connect;
    endproperty
    a_clamp_bot: assert property (p_clamp_bot)
        else $error("bottom clamp with wrong source connection");
    property p_one_end;
        !$rose(presetn) && !ladder_run |-> top_connect != bottom_connect;
    endproperty
    a_one_end: assert property (p_one_end)
        else $error("idle ladder does not drop exactly one source");
    property p_pin_ovr;
        ref_to_pin |-> pin_oe_n && !pin_out;
    endproperty
    a_pin_ovr: assert property (p_pin_ovr)
        else $error("pin driver not overridden while routed");
    property p_pin_read;
        ref_to_pin |-> !pin_digital_read;
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("routed pin reads high");
    property p_reset;
        $rose(presetn) |-> !ladder_run && !ref_to_pin;
    endproperty
    a_reset: assert property (p_reset)
        else $error("converter or pin route active after reset");
endmodule
bind ladder_dac_control ladder_dac_control_asserts #(
    .LEVEL_BITS(LEVEL_BITS)) u_chk (.pclk, .presetn, .pin_digital_read,
    .pin_out, .pin_oe_n, .ladder_run, .ladder_tap, .bottom_src,
    .top_connect, .bottom_connect, .clamp_top, .clamp_bottom, .ref_to_pin);

/* test/tb_ladder_dac_control.sv */
// self-checking bench for the ladder converter control block
`timescale 1ns/100ps
`include "ladder_dac_regs.vh"
module tb_ladder_dac_control;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, din = 1'h1, pout = 1'h1, poe_n = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, ladder_tap;
    logic        pready, pslverr, err, pin_digital_read, pin_out, pin_oe_n;
    logic        ladder_run, ref_to_pin, top_connect, bottom_connect;
    logic        clamp_top, clamp_bottom;
    logic [2:0]  top_src;
    logic [1:0]  bottom_src;
    int          n_mismatch = 0, checks_done = 0;
    ladder_dac_control uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_digital_in(din),
        .pin_port_out(pout), .pin_port_oe_n(poe_n), .pin_digital_read,
        .pin_out, .pin_oe_n, .ladder_run, .ladder_tap, .top_src, .bottom_src,
        .top_connect, .bottom_connect, .clamp_top, .clamp_bottom, .ref_to_pin);
    always #2 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd, 32'h14);
        apb(1'h1, `LEVEL_SEL_OFFSET, 32'hff);
        apb(1'h0, `LEVEL_SEL_OFFSET, 32'h0);
        chk(rd, 32'h1f);
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'h80);
        for (int k = 0; k < 32; k++) begin
            apb(1'h1, `LEVEL_SEL_OFFSET, k);
            settle;
            chk(ladder_tap, 32'h1 << k);
        end
        chk({clamp_top, top_connect, bottom_connect, ladder_run}, 4'h7);
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'h40);
        settle;
        chk({clamp_top, top_connect, bottom_connect}, 3'h6);
        chk(ladder_tap, 32'h0);
        for (int s = 0; s < 8; s++) begin
            apb(1'h1, `CTRL_ZERO_OFFSET, 32'h80 | ((s >> 1) << 2) | (s & 1));
            settle;
            chk(top_src, (s >> 1) == 3 ? 3'h0 : 3'h1 << (s >> 1));
            chk(bottom_src, 2'h1 << (s & 1));
        end
        apb(1'h1, `LEVEL_SEL_OFFSET, 32'h0);
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'h20);
        settle;
        chk({clamp_bottom, bottom_connect, top_connect}, 3'h6);
        chk({pin_out, pin_oe_n, ref_to_pin}, 3'h3);
        chk(pin_digital_read, 1'h0);
        apb(1'h0, 12'h00c, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'h1, 12'h00c, 32'h0);
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'ha0);
        // converter off before the idle stretch, pin route kept
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'h20);
        repeat (20) @(posedge pclk);
        apb(1'h0, `CTRL_ZERO_OFFSET, 32'h0);
        chk(rd, 32'h20);
        apb(1'h1, `CTRL_ZERO_OFFSET, 32'ha0);
        apb(1'h1, `LEVEL_SEL_OFFSET, 32'h15);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `CTRL_ZERO_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, `LEVEL_SEL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        settle;
        chk({pin_digital_read, pin_out, pin_oe_n, ref_to_pin}, 4'hc);
        finish_test;
    end
endmodule
